// file: hdl/qdm_pkg.sv
// Shared constants and types for the quad driver mode control block
package qdm_pkg;

   // ****************************************************************
   // Serial word layout
   // ****************************************************************
   localparam int          WORD_WIDTH     = 8;
   localparam int          CHAN_COUNT     = 4;
   localparam int          BIT_CH1_EN     = 7;   // Channels 2..4 follow downward to bit 4
   localparam int          BIT_CH4_EN     = 4;
   localparam int          BIT_LOW_LEAK   = 3;
   localparam int          BIT_TERM_SEL   = 0;

   // ****************************************************************
   // Values after reset and synchroniser depth
   // ****************************************************************
   localparam logic        RST_LOW_LEAK   = 1'b1;
   localparam logic        RST_TERM_SEL   = 1'b0;
   localparam logic [7:0]  RST_SHIFT_WORD = 8'h00;
   localparam int          SYNC_STAGES    = 2;

   // Per-channel output selection
   typedef enum logic [2:0] {
      MODE_LOW_LEAK,
      MODE_DRIVE_HIGH,
      MODE_DRIVE_LOW,
      MODE_TERM,
      MODE_HIGH_Z
   } qdm_mode_e;

endpackage

// file: hdl/qdm_sync.sv
// Two-flop synchroniser bank for pins entering the clk domain
`timescale 1ns/1ps
`default_nettype none

module qdm_sync #(
   parameter int         WIDTH     = 1,
   parameter logic [0:0] RESET_VAL = 1'b0
) (
   input  wire logic             clk,
   input  wire logic             rst,
   input  wire logic [WIDTH-1:0] d,
   output var  logic [WIDTH-1:0] q
);

   logic [WIDTH-1:0] meta;

   // A bank of no bits cannot be built
   if (WIDTH < 1) begin : g_bad_width
      $error("qdm_sync: WIDTH must be at least one");
   end

   // First stage feeds only the second stage
   always_ff @(posedge clk) begin
      if (rst) begin
         meta <= {WIDTH{RESET_VAL}};
         q    <= {WIDTH{RESET_VAL}};
      end else begin
         meta <= d;
         q    <= meta;
      end
   end

endmodule

`default_nettype wire

// file: hdl/qdm_top.sv
// Serial control port and per-channel output mode logic of the quad driver
`timescale 1ns/1ps
`default_nettype none

// Operation
// - Eight-bit shift register, MSB first
// - Latch word only when chip select rises
// - D7..D4 enable channels one to four
// - Two latched bits per channel
// - D3 selects low-leakage for enabled channels
// - D0 selects termination for enabled channels
// - D2 and D1 ignored
// - Power-up: enables, term zero; leak one
// - Reset pin forces leak, keeps others
// - Mux selects high, low or termination
// - Drive mode follows level select
// - Receive mode: termination or high impedance
// - Low-leakage overrides all other inputs
// - Low-leakage held per channel
// - Reset pin asynchronous, active low
// - Chip select low frames a transfer
// - Serial clock times shifting
module qdm_top
   import qdm_pkg::*;
#(
   parameter int NUM_CH = CHAN_COUNT
) (
   input  wire logic              clk,
   input  wire logic              rst,
   input  wire logic              ser_rst_n,
   input  wire logic              cs_n,
   input  wire logic              sclk,
   input  wire logic              din,
   input  wire logic [NUM_CH-1:0] level_select_in_n,
   input  wire logic [NUM_CH-1:0] receive_select_in,
   output var  qdm_mode_e         channel_output [NUM_CH]
);

   // ****************************************************************
   // Parameter check
   // ****************************************************************
   // The word layout fixes the channel count
   if (NUM_CH != CHAN_COUNT || BIT_CH1_EN - BIT_CH4_EN + 1 != NUM_CH) begin : g_bad_ch
      $error("qdm_top: NUM_CH must equal the channel count of the word");
   end

   // ****************************************************************
   // Pin synchronisers
   // ****************************************************************
   logic              cs_n_s;
   logic              sclk_s;
   logic              din_s;
   logic [NUM_CH-1:0] level_n_s;
   logic [NUM_CH-1:0] rcv_s;
   logic              sclk_d;
   logic              cs_n_d;
   logic              sclk_rise;
   logic              cs_rise;
   logic              leak_rst_meta_n;
   logic              leak_rst_n;

   // Chip select idles high so no frame is seen during reset
   qdm_sync #(.WIDTH(1), .RESET_VAL(1'b1)) u_sync_cs (
      .clk (clk),
      .rst (rst),
      .d   (cs_n),
      .q   (cs_n_s)
   );

   // Data and clock share one bank so they keep equal latency
   qdm_sync #(.WIDTH(2 + 2 * NUM_CH), .RESET_VAL(1'b0)) u_sync_data (
      .clk (clk),
      .rst (rst),
      .d   ({sclk, din, level_select_in_n, receive_select_in}),
      .q   ({sclk_s, din_s, level_n_s, rcv_s})
   );

   // Pin reset asserts at once but releases on clk, so no latch leaves it mid-edge
   always_ff @(posedge clk or negedge ser_rst_n) begin
      if (!ser_rst_n) begin
         leak_rst_meta_n <= 1'b0;
         leak_rst_n      <= 1'b0;
      end else begin
         leak_rst_meta_n <= 1'b1;
         leak_rst_n      <= leak_rst_meta_n;
      end
   end

   // Edge history of synchronised serial pins
   always_ff @(posedge clk) begin
      if (rst) begin
         sclk_d <= 1'b0;
         cs_n_d <= 1'b1;
      end else begin
         sclk_d <= sclk_s;
         cs_n_d <= cs_n_s;
      end
   end

   assign sclk_rise = sclk_s && !sclk_d;
   assign cs_rise   = cs_n_s && !cs_n_d;

   // ****************************************************************
   // Serial shift register
   // ****************************************************************
   logic [WORD_WIDTH-1:0] shift_word;

   // MSB enters first and walks up; clock ignored outside a frame
   always_ff @(posedge clk) begin
      if (rst) begin
         shift_word <= RST_SHIFT_WORD;
      end else if (sclk_rise && !cs_n_s) begin
         shift_word <= {shift_word[WORD_WIDTH-2:0], din_s};
      end
   end

   // ****************************************************************
   // Channel latches and output decode
   // ****************************************************************
   logic [NUM_CH-1:0] low_leak_bit;
   logic [NUM_CH-1:0] term_select_bit;
   qdm_mode_e         next_mode [NUM_CH];

   for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_ch
      logic chan_write_en;

      // Word taken as it stands at chip select rise, whatever the count
      assign chan_write_en = cs_rise && shift_word[BIT_CH1_EN - ch];

      // Low-leakage: async pin reset forces it, nothing else is touched
      // Release lags the pin by two clocks; a word latched then leaves low-leakage set
      always_ff @(posedge clk or negedge leak_rst_n) begin
         if (!leak_rst_n) begin
            low_leak_bit[ch] <= RST_LOW_LEAK;
         end else if (rst) begin
            low_leak_bit[ch] <= RST_LOW_LEAK;
         end else if (chan_write_en) begin
            low_leak_bit[ch] <= shift_word[BIT_LOW_LEAK];
         end
      end

      // Termination select; D2 and D1 are never looked at
      always_ff @(posedge clk) begin
         if (rst) begin
            term_select_bit[ch] <= RST_TERM_SEL;
         end else if (chan_write_en) begin
            term_select_bit[ch] <= shift_word[BIT_TERM_SEL];
         end
      end

      // Output selection from latched bits and fast inputs
      always_comb begin
         if (low_leak_bit[ch]) begin
            next_mode[ch] = MODE_LOW_LEAK;
         end else if (!rcv_s[ch]) begin
            next_mode[ch] = level_n_s[ch] ? MODE_DRIVE_LOW : MODE_DRIVE_HIGH;
         end else begin
            next_mode[ch] = term_select_bit[ch] ? MODE_TERM : MODE_HIGH_Z;
         end
      end

      // Registered so the output pin code never glitches
      always_ff @(posedge clk) begin
         if (rst) begin
            channel_output[ch] <= MODE_LOW_LEAK;
         end else begin
            channel_output[ch] <= next_mode[ch];
         end
      end
   end

   // ****************************************************************
   // Checks
   // ****************************************************************
   a_shift_msb_first: assert property (@(posedge clk) disable iff (rst)
      (sclk_rise && !cs_n_s) |=> shift_word == {$past(shift_word[6:0]), $past(din_s)})
      else $error("shift register did not take data at bit 0");

   a_clock_ignored: assert property (@(posedge clk) disable iff (rst)
      (cs_n_s || !sclk_rise) |=> $stable(shift_word))
      else $error("shift register moved outside a frame");

   a_latch_ch1: assert property (@(posedge clk) disable iff (rst || !leak_rst_n)
      (cs_rise && shift_word[7]) |=> low_leak_bit[0] == $past(shift_word[3])
                                  && term_select_bit[0] == $past(shift_word[0]))
      else $error("enabled channel one did not take new bits");

   a_latch_ch4: assert property (@(posedge clk) disable iff (rst || !leak_rst_n)
      (cs_rise && shift_word[4]) |=> low_leak_bit[3] == $past(shift_word[3])
                                  && term_select_bit[3] == $past(shift_word[0]))
      else $error("enabled channel four did not take new bits");

   a_leak_per_chan: assert property (@(posedge clk) disable iff (rst || !leak_rst_n)
      (cs_rise && shift_word[6] && !shift_word[5]) |=> $stable(low_leak_bit[2]))
      else $error("low-leakage of a disabled channel followed another");

   a_keep_disabled: assert property (@(posedge clk) disable iff (rst || !leak_rst_n)
      !(cs_rise && shift_word[4]) |=> $stable(low_leak_bit[3]) && $stable(term_select_bit[3]))
      else $error("channel four changed without its enable");

   a_no_early_latch: assert property (@(posedge clk) disable iff (rst)
      !cs_rise |=> $stable(term_select_bit))
      else $error("termination bits changed without chip select rise");

   a_pin_reset_leak: assert property (@(posedge clk) disable iff (rst)
      !ser_rst_n |-> low_leak_bit == {NUM_CH{1'b1}})
      else $error("reset pin did not force low-leakage");

   a_release_held: assert property (@(posedge clk) disable iff (rst)
      !leak_rst_n |-> low_leak_bit == {NUM_CH{1'b1}})
      else $error("low-leakage let go before reset release finished");

   a_reset_outputs: assert property (@(posedge clk)
      rst |=> channel_output[0] == MODE_LOW_LEAK && channel_output[3] == MODE_LOW_LEAK)
      else $error("outputs not in low-leakage after reset");

   a_leak_overrides: assert property (@(posedge clk) disable iff (rst)
      low_leak_bit[1] |=> channel_output[1] == MODE_LOW_LEAK)
      else $error("low-leakage channel not in low-leakage mode");

   a_drive_level: assert property (@(posedge clk) disable iff (rst)
      (!low_leak_bit[2] && !rcv_s[2]) |=>
         channel_output[2] == ($past(level_n_s[2]) ? MODE_DRIVE_LOW : MODE_DRIVE_HIGH))
      else $error("drive mode does not follow level select");

   a_receive_term: assert property (@(posedge clk) disable iff (rst)
      (!low_leak_bit[0] && rcv_s[0]) |=>
         channel_output[0] == ($past(term_select_bit[0]) ? MODE_TERM : MODE_HIGH_Z))
      else $error("receive mode does not follow termination select");

   a_reset_values: assert property (@(posedge clk)
      rst |=> low_leak_bit == {NUM_CH{1'b1}} && term_select_bit == '0)
      else $error("latch values after reset wrong");

endmodule

`default_nettype wire

// file: test/qdm_ctrl_model.sv
// Tester controller model driving the serial control port
`timescale 1ns/1ps
`default_nettype none

module qdm_ctrl_model (
   output var logic cs_n,
   output var logic sclk,
   output var logic din
);
   // ****************************************************************
   // Idle levels
   // ****************************************************************
   // Serial clock stands low outside frames
   initial begin
      cs_n = 1'b1;
      sclk = 1'b0;
      din  = 1'b0;
   end

   // ****************************************************************
   // Frame of one control word
   // ****************************************************************
   // Half period of 40 ns keeps each sclk phase well above two clk cycles
   task automatic send(input logic [7:0] w);
      send_part(w, 8);
   endtask

   // Frame of the low nbits of w, MSB first; short frames exercise odd counts
   task automatic send_part(input logic [7:0] w, input int nbits);
      cs_n = 1'b0;
      for (int i = nbits - 1; i >= 0; i--) begin
         din = w[i];
         #40 sclk = 1'b1;
         #40 sclk = 1'b0;
      end
      #40 cs_n = 1'b1;
      din = ~din;                   // Released line shows no stale bit
      #80;
   endtask

   // Serial clock pulses with chip select high; the port must ignore them
   task automatic stray_clocks(input int n);
      for (int i = 0; i < n; i++) begin
         din = ~din;
         #40 sclk = 1'b1;
         #40 sclk = 1'b0;
      end
      #40;
   endtask
endmodule
`default_nettype wire

// file: test/quad_driver_mode_control_test.sv
// Self-checking testbench of the quad driver mode control block
`timescale 1ns/1ps
`default_nettype none

module quad_driver_mode_control_test;
   import qdm_pkg::*;

   logic       clk       = 1'b0;
   logic       rst       = 1'b1;
   logic       ser_rst_n = 1'b0;
   logic [3:0] lvl_n     = 4'h0;
   logic [3:0] rcv       = 4'h0;
   wire logic  cs_n;
   wire logic  sclk;
   wire logic  din;
   qdm_mode_e  ch_out [4];
   int         err_count   = 0;
   int         check_count = 0;

   // 125 MHz clock
   always #4 clk = ~clk;

   qdm_ctrl_model qdm_ctrl_model_inst (
      .cs_n (cs_n),
      .sclk (sclk),
      .din  (din)
   );

   qdm_top #(.NUM_CH(4)) qdm_top_inst (
      .clk               (clk),
      .rst               (rst),
      .ser_rst_n         (ser_rst_n),
      .cs_n              (cs_n),
      .sclk              (sclk),
      .din               (din),
      .level_select_in_n (lvl_n),
      .receive_select_in (rcv),
      .channel_output    (ch_out)
   );

   // ****************************************************************
   // Helpers
   // ****************************************************************
   task automatic check(input logic [2:0] seen, input logic [2:0] exp);
      check_count++;
      if (seen !== exp) begin
         err_count++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   // Index 0 is channel one
   task automatic chk4(input qdm_mode_e a, input qdm_mode_e b, input qdm_mode_e c, input qdm_mode_e d);
      qdm_mode_e e [4];
      e = '{a, b, c, d};
      for (int i = 0; i < 4; i++) begin
         check(ch_out[i], e[i]);
      end
   endtask

   // Synchroniser plus output flop need a few clk before the result shows
   task automatic settle();
      repeat (6) @(posedge clk);
      #1;
   endtask

   task automatic send(input logic [7:0] w);
      qdm_ctrl_model_inst.send(w);
      settle();
   endtask

   task automatic report_and_stop();
      $display("checks=%0d errors=%0d", check_count, err_count);
      if (err_count == 0 && check_count > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   // ****************************************************************
   // Tests
   // ****************************************************************
   // Serial reset held low with system reset, as at power-up
   initial begin
      repeat (3) @(posedge clk);
      #1;
      rst = 1'b0;
      ser_rst_n = 1'b1;
      settle();
      chk4(MODE_LOW_LEAK, MODE_LOW_LEAK, MODE_LOW_LEAK, MODE_LOW_LEAK);
      send(8'hf0);
      chk4(MODE_DRIVE_HIGH, MODE_DRIVE_HIGH, MODE_DRIVE_HIGH, MODE_DRIVE_HIGH);
      lvl_n = 4'b1010;
      settle();
      chk4(MODE_DRIVE_HIGH, MODE_DRIVE_LOW, MODE_DRIVE_HIGH, MODE_DRIVE_LOW);
      rcv = 4'hf;
      send(8'h87);
      chk4(MODE_TERM, MODE_HIGH_Z, MODE_HIGH_Z, MODE_HIGH_Z);
      send(8'h48);
      chk4(MODE_TERM, MODE_LOW_LEAK, MODE_HIGH_Z, MODE_HIGH_Z);
      send(8'h0f);
      chk4(MODE_TERM, MODE_LOW_LEAK, MODE_HIGH_Z, MODE_HIGH_Z);
      ser_rst_n = 1'b0;
      settle();
      chk4(MODE_LOW_LEAK, MODE_LOW_LEAK, MODE_LOW_LEAK, MODE_LOW_LEAK);
      ser_rst_n = 1'b1;
      settle();
      send(8'h70);
      chk4(MODE_LOW_LEAK, MODE_HIGH_Z, MODE_HIGH_Z, MODE_HIGH_Z);
      send(8'h80);
      chk4(MODE_HIGH_Z, MODE_HIGH_Z, MODE_HIGH_Z, MODE_HIGH_Z);
      rcv = 4'h0;
      settle();
      chk4(MODE_DRIVE_HIGH, MODE_DRIVE_LOW, MODE_DRIVE_HIGH, MODE_DRIVE_LOW);
      // No enables: word sits in the shift register only
      send(8'h0f);
      chk4(MODE_DRIVE_HIGH, MODE_DRIVE_LOW, MODE_DRIVE_HIGH, MODE_DRIVE_LOW);
      // Stray clocks must not shift; four bits then complete the word 8'hf8
      qdm_ctrl_model_inst.stray_clocks(4);
      qdm_ctrl_model_inst.send_part(8'h08, 4);
      settle();
      chk4(MODE_LOW_LEAK, MODE_LOW_LEAK, MODE_LOW_LEAK, MODE_LOW_LEAK);
      report_and_stop();
   end

   // Watchdog well beyond the eight frames above
   initial begin
      #200000;
      err_count++;
      report_and_stop();
   end
endmodule
`default_nettype wire
